// >>> verilog/vx_defs.svh
// Constants for the vector-extension exception and issue-timing unit.
// Assumes big-endian bit numbering of the core (bit 0 is the MSB of a word).
`ifndef VX_DEFS_SVH
`define VX_DEFS_SVH

// Special-register number of the unavailable-vector offset register
`define SPRN_UNAVAIL_OFFSET   10'h210
`define SPRN_ALIGN_OFFSET     10'h03F
`define SPRN_VECTOR_PREFIX    10'h03F0
// Machine-state bits kept on entry (critical, machine-check, debug enable)
`define MSW_KEEP_MASK         32'h0002_1200
`define MSW_VU_ENABLE_BIT     6
// Syndrome bits, LSB numbering (bit 24 big-endian is bit 7 LSB-first)
`define SYN_VECTOR_BIT        7
`define SYN_STORE_BIT         8
// Handler address fields: prefix [31:16], offset [15:4], zero [3:0]
`define VEC_OFFSET_MASK       32'h0000_FFF0
`define VEC_PREFIX_MASK       32'hFFFF_0000
// Divide latency bounds in cycles
`define DIV_LAT_MIN           6'd12
`define DIV_LAT_MAX           6'd32
`define SIMPLE_LAT            6'd1
`define OFFSET_RESET          32'h0000_0000

`endif

// >>> verilog/vx_pkg.sv
// Types for the vector-extension exception and issue-timing unit.
// Assumes vx_defs.svh supplies all numeric constants.
package vx_pkg;

  typedef enum logic [1:0] {
    op_none  = 2'b00,
    op_simple= 2'b01,
    op_div   = 2'b11,
    op_ldst  = 2'b10
  } op_class_t;

  typedef struct packed {
    logic        valid;
    logic        is_vec;
    logic        is_brinc;
    op_class_t   cls;
    logic        dw_ldst;
    logic        is_store;
    logic [5:0]  div_lat;
    logic [31:0] pc;
    logic [31:0] ea;
  } issue_t;

  typedef struct packed {
    logic        take;
    logic        unavail;
    logic [31:0] pc_save;
    logic [31:0] state_save;
    logic [31:0] new_state;
    logic [31:0] syndrome;
    logic        fault_addr_we;
    logic [31:0] fault_addr;
    logic [31:0] handler;
  } entry_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_div  = 2'b01
  } div_state_t;

endpackage

// >>> verilog/vx_div_timer.sv
// Unpipelined divide occupancy counter.
// Assumes the issuing logic starts it only while it reports idle.
`timescale 1ns/1ns
`default_nettype none
module vx_div_timer
  import vx_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic [5:0] lat,
  output logic            busy,
  output logic            ending
);
`include "vx_defs.svh"

  typedef struct packed {
    div_state_t st;
    logic [5:0] cnt;
  } dstate_t;

  dstate_t s_r;
  dstate_t s_nxt;

  // Clamp requested latency to the documented range
  function automatic logic [5:0] clamp_lat(input logic [5:0] l);
    if (l < `DIV_LAT_MIN) begin
      clamp_lat = `DIV_LAT_MIN;
    end else if (l > `DIV_LAT_MAX) begin
      clamp_lat = `DIV_LAT_MAX;
    end else begin
      clamp_lat = l;
    end
  endfunction

  // Count down the remaining divide cycles; busy covers the whole latency
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      st_idle: begin
        if (start) begin
          s_nxt.st  = st_div;
          s_nxt.cnt = clamp_lat(lat) - 6'h01;
        end
      end
      st_div: begin
        if (s_r.cnt == 6'h00) begin
          s_nxt.st = st_idle;
        end else begin
          s_nxt.cnt = s_r.cnt - 6'h01;
        end
      end
      default: s_nxt.st = st_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '{st: st_idle, cnt: 6'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = (s_r.st == st_div);
  // Last busy cycle; lets the issuer drop its stall flop on the freeing edge
  assign ending = (s_r.st == st_div) && (s_r.cnt == 6'h00);

endmodule
`default_nettype wire

// >>> verilog/vx_exc_unit.sv
// Vector-extension exception detection, interrupt entry and issue timing.
// Assumes decode presents one instruction per cycle on iss and holds it
// while stall is high; the sequencer consumes entry when entry.take is set.
//
// Overview of operation
// - Unavailable fault when vector enable clear and non-brinc vector op issued.
// - Unavailable fault suppresses the instruction; no result is committed.
// - Either fault saves instruction address and prior machine state.
// - Entry keeps critical, machine-check, debug enables; clears other state bits.
// - Unavailable fault sets only the syndrome vector flag.
// - Unavailable handler is prefix high half, offset bits, four zeros.
// - Unavailable offset at special register 528, privileged access only.
// - Double-word vector load/store off a 32-bit boundary raises alignment fault.
// - Alignment fault suppresses the instruction, enters general alignment interrupt.
// - Alignment fault sets vector flag, store flag for stores only.
// - Alignment fault loads fault address with the effective address.
// - Alignment handler is prefix high half, alignment offset, four zeros.
// - Unavailable fault takes priority over alignment fault.
// - Divide is unpipelined and blocks all other instructions.
// - Divide takes 12 to 32 cycles; followers stall that long.
// - Simple arithmetic issues as an operation pair, latency and throughput 1.
// - Logical, shift, compare, set, select complete in 1 cycle, every cycle.
`timescale 1ns/1ns
`default_nettype none
module vx_exc_unit
  import vx_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire issue_t      iss,
  input  wire logic [31:0] machine_state_word,
  input  wire logic        privileged,
  input  wire logic        spr_we,
  input  wire logic        spr_re,
  input  wire logic [9:0]  spr_num,
  input  wire logic [31:0] spr_wdata,
  output logic [31:0]      spr_rdata,
  output logic             spr_priv_fault,
  output entry_t           entry,
  output logic             commit,
  output logic             pair_issue,
  output logic             stall
);
`include "vx_defs.svh"

  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] unavail_ofs;
    logic [31:0] align_ofs;
    logic [31:0] prefix;
    logic [31:0] rdata;
    logic        priv_fault;
    entry_t      ent;
    logic        commit;
    logic        pair;
    logic        stall;
  } ustate_t;

  ustate_t s_r;
  ustate_t s_nxt;
  logic    div_busy;
  logic    div_start;
  logic    div_ending;
  logic    fault_unavail;
  logic    fault_align;
  logic    issue_ok;

  // Handler address from prefix and offset, low nibble forced zero
  function automatic logic [31:0] handler_addr(input logic [31:0] pre,
                                               input logic [31:0] ofs);
    handler_addr = (pre & `VEC_PREFIX_MASK) | (ofs & `VEC_OFFSET_MASK);
  endfunction

  // Entry record shared by both fault kinds
  function automatic entry_t make_entry(input issue_t i, input logic [31:0] msw);
    make_entry               = '0;
    make_entry.take          = 1'b1;
    make_entry.pc_save       = i.pc;
    make_entry.state_save    = msw;
    make_entry.new_state     = msw & `MSW_KEEP_MASK;
    make_entry.syndrome      = 32'h0000_0000;
    make_entry.syndrome[`SYN_VECTOR_BIT] = 1'b1;
  endfunction

  // ==========================================================
  // Divide occupancy
  vx_div_timer u_div (
    .mclk  (mclk),
    .reset (reset),
    .start (div_start),
    .lat   (iss.div_lat),
    .busy  (div_busy),
    .ending(div_ending)
  );

  // ==========================================================
  // Fault detection, combinational so nothing commits first
  always_comb begin
    fault_unavail = iss.valid && iss.is_vec && !iss.is_brinc
                    && !machine_state_word[`MSW_VU_ENABLE_BIT];
    fault_align   = iss.valid && iss.is_vec && iss.dw_ldst
                    && (iss.ea[1:0] != 2'b00);
    // The divider blocks every issue while it runs
    issue_ok      = iss.valid && !div_busy;
    div_start     = issue_ok && !fault_unavail && !fault_align
                    && (iss.cls == op_div);
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt            = s_r;
    s_nxt.ent        = '0;
    s_nxt.commit     = 1'b0;
    s_nxt.pair       = 1'b0;
    s_nxt.priv_fault = 1'b0;
    // Stall flop tracks the divider's busy flop edge for edge, so a held
    // follower is released on exactly the edge that the divider frees up
    s_nxt.stall      = div_start || (div_busy && !div_ending);

    // Special-register access, privileged only
    if (spr_we || spr_re) begin
      if (!privileged) begin
        s_nxt.priv_fault = 1'b1;
      end else if (spr_num == `SPRN_UNAVAIL_OFFSET) begin
        if (spr_we) s_nxt.unavail_ofs = spr_wdata;
        s_nxt.rdata = s_r.unavail_ofs;
      end else if (spr_num == `SPRN_ALIGN_OFFSET) begin
        if (spr_we) s_nxt.align_ofs = spr_wdata;
        s_nxt.rdata = s_r.align_ofs;
      end else if (spr_num == `SPRN_VECTOR_PREFIX) begin
        if (spr_we) s_nxt.prefix = spr_wdata;
        s_nxt.rdata = s_r.prefix;
      end else begin
        s_nxt.rdata = 32'h0000_0000;
      end
    end

    if (issue_ok) begin
      if (fault_unavail) begin
        // Unavailable wins when both faults apply
        s_nxt.ent         = make_entry(iss, machine_state_word);
        s_nxt.ent.unavail = 1'b1;
        s_nxt.ent.handler = handler_addr(s_r.prefix, s_r.unavail_ofs);
      end else if (fault_align) begin
        s_nxt.ent = make_entry(iss, machine_state_word);
        s_nxt.ent.syndrome[`SYN_STORE_BIT] = iss.is_store;
        s_nxt.ent.fault_addr_we = 1'b1;
        s_nxt.ent.fault_addr    = iss.ea;
        s_nxt.ent.handler = handler_addr(s_r.prefix, s_r.align_ofs);
      end else begin
        // Every non-faulting class, divide included, commits the cycle after issue
        s_nxt.commit = 1'b1;
        s_nxt.pair   = (iss.cls == op_simple);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r             <= '0;
      s_r.unavail_ofs <= `OFFSET_RESET;
      s_r.align_ofs   <= `OFFSET_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign spr_rdata      = s_r.rdata;
  assign spr_priv_fault = s_r.priv_fault;
  assign entry          = s_r.ent;
  assign commit         = s_r.commit;
  assign pair_issue     = s_r.pair;
  assign stall          = s_r.stall;

  // ==========================================================
  // Checks
  sequence unav_issue_s;
    iss.valid && iss.is_vec && !iss.is_brinc && !div_busy
      && !machine_state_word[`MSW_VU_ENABLE_BIT];
  endsequence

  unavail_take_a: assert property (@(posedge mclk) disable iff (reset)
    unav_issue_s |=> entry.take && entry.unavail)
    else $error("unavailable fault not taken");

  unavail_supp_a: assert property (@(posedge mclk) disable iff (reset)
    unav_issue_s |=> !commit)
    else $error("faulting instruction committed");

  save_pc_a: assert property (@(posedge mclk) disable iff (reset)
    unav_issue_s |=> entry.pc_save == $past(iss.pc))
    else $error("saved pc wrong");

  state_keep_a: assert property (@(posedge mclk) disable iff (reset)
    entry.take |-> (entry.new_state & ~`MSW_KEEP_MASK) == 32'h0000_0000)
    else $error("entry state not cleared");

  syn_only_a: assert property (@(posedge mclk) disable iff (reset)
    entry.take && entry.unavail |-> entry.syndrome == 32'h0000_0080)
    else $error("unavailable syndrome wrong");

  handler_low_a: assert property (@(posedge mclk) disable iff (reset)
    entry.take |-> entry.handler[3:0] == 4'h0)
    else $error("handler low bits set");

  priv_spr_a: assert property (@(posedge mclk) disable iff (reset)
    (spr_we && !privileged) |=> spr_priv_fault)
    else $error("user access not refused");

  align_take_a: assert property (@(posedge mclk) disable iff (reset)
    (iss.valid && iss.is_vec && iss.dw_ldst && iss.ea[1:0] != 2'b00 && !div_busy)
      |=> entry.take && !commit)
    else $error("alignment fault missed");

  align_addr_a: assert property (@(posedge mclk) disable iff (reset)
    entry.take && !entry.unavail |-> entry.fault_addr_we)
    else $error("fault address not loaded");

  div_block_a: assert property (@(posedge mclk) disable iff (reset)
    div_start |=> stall [*8])
    else $error("divide did not block");

  div_max_a: assert property (@(posedge mclk) disable iff (reset)
    div_start |-> ##[13:33] !stall)
    else $error("divide stall too long");

endmodule
`default_nettype wire

// >>> verif/vx_issue_model.sv
// Issue-stage stand-in: presents one instruction and holds it while stalled.
// Assumes the bench pulses go with req steady; go replaces the held instruction.
`timescale 1ns/1ns
`default_nettype none
module vx_issue_model
  import vx_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   reset,
  input  wire logic   go,
  input  wire issue_t req,
  input  wire logic   stall,
  output issue_t      iss
);
  // ==========================================================
  // Hold while stalled; once taken, scramble the stale fields
  always_ff @(posedge mclk) begin
    if (reset) begin
      iss <= '0;
    end else if (go) begin
      iss <= req;
    end else if (iss.valid && !stall) begin
      iss <= {1'b0, ~iss[$bits(issue_t)-2:0]}; // Stale fields never look valid
    end
  end
endmodule
`default_nettype wire

// >>> verif/vector_ext_exception_timing_tb_top.sv
// Bench for the vector-extension exception unit, fed by an issue-stage model.
// Assumes the unit answers within four cycles of taking an instruction.
`timescale 1ns/1ns
`default_nettype none
`include "vx_defs.svh"
module vector_ext_exception_timing_tb_top;
  import vx_pkg::*;
  logic        mclk, reset, go, privileged, spr_we, spr_re, priv_f, commit, pair, stall;
  logic [9:0]  spr_num;
  logic [31:0] msw, spr_wdata, rdata;
  issue_t      req, iss;
  entry_t      entry, got;
  int          n_mismatch, checks, seen;

  vx_issue_model model (.mclk(mclk), .reset(reset), .go(go), .req(req), .stall(stall),
                        .iss(iss));
  vx_exc_unit dut (.mclk(mclk), .reset(reset), .iss(iss), .machine_state_word(msw),
    .privileged(privileged), .spr_we(spr_we), .spr_re(spr_re), .spr_num(spr_num),
    .spr_wdata(spr_wdata), .spr_rdata(rdata), .spr_priv_fault(priv_f), .entry(entry),
    .commit(commit), .pair_issue(pair), .stall(stall));

  // ==========================================================
  // Shared helpers
  // Wide enough for the flag-plus-word pairs compared below
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic spr(input logic w, input logic [9:0] n, input logic [31:0] d);
    @(posedge mclk);
    spr_we <= w;
    spr_re <= !w;
    spr_num <= n;
    spr_wdata <= d;
    @(posedge mclk);
    spr_we <= 1'b0;
    spr_re <= 1'b0;
    #1;
  endtask
  function automatic issue_t mk(input op_class_t c, input logic dw, st, br,
                                input logic [31:0] ea);
    mk = '0;
    mk.valid = 1'b1;
    mk.is_vec = 1'b1;
    mk.is_brinc = br;
    mk.cls = c;
    mk.dw_ldst = dw;
    mk.is_store = st;
    mk.pc = 32'h0000_1000 + ea;
    mk.ea = ea;
  endfunction
  task automatic issue(input issue_t r);
    @(posedge mclk);
    req <= r;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask
  // Capture any entry and note any commit over a short window
  task automatic wait_out();
    got = '0;
    seen = 0;
    repeat (4) begin
      @(posedge mclk);
      #1;
      if (entry.take === 1'b1) got = entry;
      if (commit === 1'b1) seen = 1;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_spr();
    spr(0, `SPRN_UNAVAIL_OFFSET, 32'h0);
    check(rdata, `OFFSET_RESET);
    spr(1, `SPRN_UNAVAIL_OFFSET, 32'hABCD_0A5F);
    spr(1, `SPRN_ALIGN_OFFSET, 32'h0000_056C);
    spr(1, `SPRN_VECTOR_PREFIX, 32'h1234_5678);
    privileged <= 1'b0;
    spr(1, `SPRN_UNAVAIL_OFFSET, 32'hFFFF_FFFF);
    check(priv_f, 1);
    privileged <= 1'b1;
    spr(0, `SPRN_UNAVAIL_OFFSET, 32'h0);
    check(rdata, 32'hABCD_0A5F);
  endtask
  task automatic t_unavail();
    msw <= 32'hFFFF_FFBF; // Enable bit clear, all else set
    issue(mk(op_simple, 0, 0, 0, 32'h0000_0010));
    wait_out();
    check(got.take, 1);
    check(seen, 0);
    check(got.unavail, 1);
    check(got.pc_save, 32'h0000_1010);
    check(got.state_save, 32'hFFFF_FFBF);
    check(got.new_state, `MSW_KEEP_MASK);
    check(got.syndrome, 32'h0000_0080);
    check(got.handler, 32'h1234_0A50);
    issue(mk(op_simple, 0, 0, 1, 32'h0));
    wait_out();
    check(got.take, 0);
    check(seen, 1);
  endtask
  task automatic t_align();
    msw <= 32'h0000_0040;
    for (int s = 0; s < 2; s++) begin
      issue(mk(op_ldst, 1, s[0], 0, 32'h0000_2002));
      wait_out();
      check(got.take, 1);
      check({seen[0], got.unavail}, 0);
      check(got.state_save, 32'h0000_0040);
      check(got.new_state, 32'h0);
      check(got.syndrome, {23'h0, s[0], 8'h80});
      check({got.fault_addr_we, got.fault_addr}, 33'h1_0000_2002);
      check(got.handler, 32'h1234_0560);
    end
    issue(mk(op_ldst, 1, 0, 0, 32'h0000_2004));
    wait_out();
    check({got.take, seen[0]}, 1);
    msw <= 32'h0000_0000; // Both faults at once
    issue(mk(op_ldst, 1, 1, 0, 32'h0000_3001));
    wait_out();
    check({got.unavail, got.syndrome}, 33'h1_0000_0080);
  endtask
  // Divide blocks issue; the held follower must not pair while stalled
  task automatic t_div(input logic [5:0] lat, input int exp);
    issue_t r;
    int     st_n, pr_s, pr_n;
    st_n = 0;
    pr_s = 0;
    pr_n = 0;
    msw <= 32'h0000_0040;
    r = mk(op_div, 0, 0, 0, 32'h0);
    r.div_lat = lat;
    issue(r);
    // Follower offered on the divide's take edge so every stall cycle is seen
    for (int i = 0; i < 45; i++) begin
      @(posedge mclk);
      req <= mk(op_simple, 0, 0, 0, 32'h0);
      go  <= (i == 0);
      #1;
      st_n += (stall === 1'b1);
      pr_s += (stall === 1'b1 && pair === 1'b1);
      pr_n += (pair === 1'b1);
    end
    check(st_n, exp);
    check(pr_s, 0);
    check(pr_n, 1);
  endtask
  task automatic t_simple();
    int n;
    n = 0;
    @(posedge mclk);
    req <= mk(op_simple, 0, 0, 0, 32'h0);
    go <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      if (i == 2) go <= 1'b0;
      #1;
      n += (pair === 1'b1 && commit === 1'b1);
    end
    check(n, 3);
  endtask

  // ==========================================================
  // Clock, watchdog, sequence and verdict
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    reset = 1'b1;
    go = 1'b0;
    req = '0;
    msw = 32'h0;
    privileged = 1'b1;
    spr_we = 1'b0;
    spr_re = 1'b0;
    spr_num = 10'h0;
    spr_wdata = 32'h0;
    n_mismatch = 0;
    checks = 0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    t_spr();
    t_unavail();
    t_align();
    t_div(6'd5, 12);
    t_div(6'd20, 20);
    t_div(6'd40, 32);
    t_simple();
    finish_test();
  end
endmodule
`default_nettype wire
